// ---- src/dual_uart_map.svh ----
`ifndef DUAL_UART_MAP_SVH
`define DUAL_UART_MAP_SVH

// Register offsets inside one channel's register set
`define REG_HOLD      3'h0
`define REG_IER       3'h1
`define REG_ISR       3'h2
`define REG_LCR       3'h3
`define REG_MCR       3'h4
`define REG_LSR       3'h5
`define REG_MSR       3'h6
`define REG_SPR       3'h7

// Field positions
`define LCR_DLAB      7
`define MCR_DTR       0
`define MCR_RTS       1
`define MCR_OP2       3
`define IER_MODEM     3
`define AFR_CONC      0
`define AFR_SEL_LO    1
`define AFR_SEL_HI    2
`define MSR_RI        2

// Reset and fixed values
`define CTL_RST       8'h00
`define AFR_RST       8'h00
`define AFR_USED_MASK 8'h07
`define ISR_RST       8'h01
`define ISR_MODEM     8'h00
`define LSR_RST       8'h60
`define MSR_DELTA_RST 4'h0
`define MODEM_IDLE    4'hf
`define RHR_EMPTY     8'h00
`define PRIME_DONE    2'h3
`define CTL_IDLE      3'h7
`define PINS_RST      8'hf1
`define MF_RST        2'h3

`endif

// ---- src/dual_uart_pkg.sv ----
package dual_uart_pkg;

  // Multi-function pin source codes
  typedef enum logic [1:0] {
    MF_OP2   = 2'b00,
    MF_BAUD  = 2'b01,
    MF_RX_DMA_READY = 2'b10,
    MF_RSVD  = 2'b11
  } mf_sel_e;

  // Modem inputs, active low, ordered like the upper status nibble
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } modem_in_s;

  // Pin-level values produced by one channel
  typedef struct packed {
    logic serial_out;
    logic op2_n;
    logic rts_n;
    logic dtr_n;
    logic irq;
    logic tx_rdy;
    logic baud_out;
    logic rx_rdy_n;
  } chan_pins_s;

  // Whole state of one channel register set
  typedef struct packed {
    logic [7:0]  irq_enable_reg;
    logic [7:0]  line_control_reg;
    logic [7:0]  modem_control_reg;
    logic [7:0]  fifo_control_reg;
    logic [7:0]  scratch_byte;
    logic [7:0]  dll;
    logic [7:0]  dlm;
    logic [3:0]  delta;
    logic [3:0]  m1;
    logic [3:0]  m2;
    logic [3:0]  mprev;
    logic [1:0]  prime;
    logic [15:0] baud_cnt;
    logic        baud_lvl;
  } chan_state_s;

  // Whole state of the top level
  typedef struct packed {
    logic [2:0] s1_ctl;
    logic [2:0] s2_ctl;
    logic [2:0] prev_ctl;
    logic [2:0] s1_addr;
    logic [2:0] s2_addr;
    logic       s1_chsel;
    logic       s2_chsel;
    logic [7:0] s1_data;
    logic [7:0] s2_data;
    logic [7:0] alternate_function_select;
    logic [7:0] dout;
    logic       oe_n;
    chan_pins_s pa;
    chan_pins_s pb;
    logic [1:0] mf;
  } top_state_s;

endpackage

// ---- src/uart_channel_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dual_uart_map.svh"

module uart_channel_regs (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Register access
  input  wire logic                     wr_stb,
  input  wire logic                     rd_done,
  input  wire logic [2:0]               addr,
  input  wire logic [7:0]               wdata,
  output logic      [7:0]               rd_data,
  output logic                          dlab,
  // Modem pins in, channel pin values out
  input  wire dual_uart_pkg::modem_in_s modem_in_n,
  output dual_uart_pkg::chan_pins_s     pins
);

  dual_uart_pkg::chan_state_s st_reg;   // Registered state
  dual_uart_pkg::chan_state_s st_next;  // Next state
  logic [3:0]  delta_set;               // Change events this cycle
  logic [15:0] divisor;                 // Baud divisor

  assign divisor = {st_reg.dlm, st_reg.dll};
  assign dlab    = st_reg.line_control_reg[`LCR_DLAB];

  // Next state: writes, modem change capture, baud divider
  always_comb begin
    st_next       = st_reg;
    st_next.m1    = modem_in_n;
    st_next.m2    = st_reg.m1;
    st_next.mprev = st_reg.m2;
    // Comparison waits until the synchroniser holds real pin values
    if (st_reg.prime != `PRIME_DONE) begin
      st_next.prime = st_reg.prime + 2'h1;
    end
    delta_set = 4'h0;
    if (st_reg.prime == `PRIME_DONE) begin
      delta_set = st_reg.m2 ^ st_reg.mprev;
      // Ring change counts only when the pin goes back high
      delta_set[`MSR_RI] = st_reg.m2[`MSR_RI] & ~st_reg.mprev[`MSR_RI];
    end
    // Read clears change bits, a new change in that cycle survives
    if (rd_done && addr == `REG_MSR) begin
      st_next.delta = `MSR_DELTA_RST;
    end
    st_next.delta = st_next.delta | delta_set;
    // Register writes
    if (wr_stb) begin
      if (addr == `REG_HOLD) begin
        if (dlab) st_next.dll = wdata;
      end else if (addr == `REG_IER) begin
        if (dlab) st_next.dlm = wdata;
        else st_next.irq_enable_reg = wdata;
      end else if (addr == `REG_ISR) begin
        if (!dlab) st_next.fifo_control_reg = wdata;
      end else if (addr == `REG_LCR) begin
        st_next.line_control_reg = wdata;
      end else if (addr == `REG_MCR) begin
        st_next.modem_control_reg = wdata;
      end else if (addr == `REG_SPR) begin
        st_next.scratch_byte = wdata; // RQ1
      end
    end
    // Baud divider; a zero divisor stops the clock
    if (divisor == 16'h0000) begin
      st_next.baud_cnt = 16'h0000;
    end else if (st_reg.baud_cnt >= divisor - 16'h0001) begin
      st_next.baud_cnt = 16'h0000;
      st_next.baud_lvl = ~st_reg.baud_lvl;
    end else begin
      st_next.baud_cnt = st_reg.baud_cnt + 16'h0001;
    end
  end

  // State register, control registers cleared by reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg       <= '0; // RQ10 RQ13
      st_reg.m1    <= `MODEM_IDLE;
      st_reg.m2    <= `MODEM_IDLE;
      st_reg.mprev <= `MODEM_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read data for the addressed register
  always_comb begin
    if (addr == `REG_HOLD) begin
      rd_data = dlab ? st_reg.dll : `RHR_EMPTY;
    end else if (addr == `REG_IER) begin
      rd_data = dlab ? st_reg.dlm : st_reg.irq_enable_reg;
    end else if (addr == `REG_ISR) begin
      rd_data = pins.irq ? `ISR_MODEM : `ISR_RST; // RQ11
    end else if (addr == `REG_LCR) begin
      rd_data = st_reg.line_control_reg;
    end else if (addr == `REG_MCR) begin
      rd_data = st_reg.modem_control_reg;
    end else if (addr == `REG_LSR) begin
      rd_data = `LSR_RST; // RQ12
    end else if (addr == `REG_MSR) begin
      rd_data = {~st_reg.m2, st_reg.delta}; // RQ13
    end else begin
      rd_data = st_reg.scratch_byte;
    end
  end

  // Pin values; no transmitter here, so serial out idles high
  always_comb begin
    pins            = '0;
    pins.serial_out = 1'b1; // RQ14
    pins.op2_n      = ~st_reg.modem_control_reg[`MCR_OP2];
    pins.rts_n      = ~st_reg.modem_control_reg[`MCR_RTS];
    pins.dtr_n      = ~st_reg.modem_control_reg[`MCR_DTR];
    pins.irq        = st_reg.irq_enable_reg[`IER_MODEM] & (|st_reg.delta);
    pins.tx_rdy     = 1'b0;
    pins.baud_out   = st_reg.baud_lvl;
    pins.rx_rdy_n   = 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  scratch_store_a: assert property ( // RQ1
    wr_stb && addr == `REG_SPR |=> st_reg.scratch_byte == $past(wdata))
    else $error("scratch byte not stored");
  ctl_reset_a: assert property ( // RQ10
    $fell(rst) |-> st_reg.irq_enable_reg == `CTL_RST && st_reg.line_control_reg == `CTL_RST
      && st_reg.modem_control_reg == `CTL_RST && st_reg.fifo_control_reg == `CTL_RST)
    else $error("control register not cleared by reset");
  isr_idle_a: assert property ( // RQ11
    $fell(rst) && addr == `REG_ISR |-> rd_data == `ISR_RST)
    else $error("interrupt source not idle after reset");
  lsr_value_a: assert property ( // RQ12
    addr == `REG_LSR |-> rd_data == `LSR_RST)
    else $error("line status value wrong");
  msr_reset_a: assert property ( // RQ13
    $fell(rst) |-> ##1 st_reg.delta == `MSR_DELTA_RST [*2])
    else $error("modem change bits set after reset");

endmodule // uart_channel_regs

`default_nettype wire

// ---- src/dual_uart_alt_function_reset.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dual_uart_map.svh"

// How it works
// RQ1 - Per-channel eight-bit scratch byte, read back unchanged
// RQ2 - Alternate function register readable and writable
// RQ3 - Alternate function bits seven to three zero
// RQ4 - Bits two-one pick multi-function pin source
// RQ5 - Each multi-function pin carries one source only
// RQ6 - Concurrent bit makes one write update both channels
// RQ7 - Concurrent bit reachable through either register set
// RQ8 - Reads follow channel select, ignore concurrent bit
// RQ9 - Host matches divisor latch bit before concurrent writes
// RQ10 - Reset clears control and alternate function registers
// RQ11 - Reset leaves interrupt source reading one
// RQ12 - Reset leaves line status bits six, five set
// RQ13 - Modem status shows pins, change bits zero
// RQ14 - Reset drives outputs high, interrupts, dma low
module dual_uart_alt_function_reset (
  // Clock and reset
  input  wire logic                     CLK,
  input  wire logic                     RESET,
  // Parallel register port
  input  wire logic                     CS_N,
  input  wire logic                     IOR_N,
  input  wire logic                     IOW_N,
  input  wire logic [2:0]               ADDR,
  input  wire logic                     CHSEL,
  input  wire logic [7:0]               DATA_IN,
  output logic      [7:0]               DATA_OUT,
  output logic                          DATA_OE_N,
  // Modem inputs
  input  wire dual_uart_pkg::modem_in_s MODEM_IN_N_A,
  input  wire dual_uart_pkg::modem_in_s MODEM_IN_N_B,
  // Channel A pins
  output logic                          SERIAL_OUT_A,
  output logic                          MULTI_FUNCTION_OUT_A,
  output logic                          SEND_REQUEST_OUT_A_N,
  output logic                          TERMINAL_READY_OUT_A_N,
  output logic                          IRQ_OUT_A,
  output logic                          TX_DMA_READY_A,
  // Channel B pins
  output logic                          SERIAL_OUT_B,
  output logic                          MULTI_FUNCTION_OUT_B,
  output logic                          SEND_REQUEST_OUT_B_N,
  output logic                          TERMINAL_READY_OUT_B_N,
  output logic                          IRQ_OUT_B,
  output logic                          TX_DMA_READY_B
);

  dual_uart_pkg::top_state_s st_reg;   // Registered state
  dual_uart_pkg::top_state_s st_next;  // Next state
  dual_uart_pkg::chan_pins_s pins [2]; // Pin values per channel
  dual_uart_pkg::modem_in_s  modem [2];
  dual_uart_pkg::mf_sel_e    mf_sel;   // Current source choice
  logic [7:0] rd_data [2];             // Per-channel read data
  logic [1:0] dlab;                    // Divisor latch bit per channel
  logic [1:0] wr;                      // Channel write pulses
  logic       wr_end;                  // Write strobe just ended
  logic       rd_end;                  // Read strobe just ended
  logic       rd_active;               // Read strobe in progress
  logic       afr_hit;                 // Access targets the function register
  logic       conc;                    // Concurrent write enabled

  // Function register sits behind the status address while the latch bit is set
  function automatic logic is_afr(input logic [2:0] a, input logic dl);
    is_afr = (a == `REG_ISR) && dl;
  endfunction

  // One source per pin, reserved code parks the pin high
  function automatic logic mf_pick(input dual_uart_pkg::mf_sel_e sel,
                                   input dual_uart_pkg::chan_pins_s p);
    case (sel)
      dual_uart_pkg::MF_OP2:   mf_pick = p.op2_n;
      dual_uart_pkg::MF_BAUD:  mf_pick = p.baud_out;
      dual_uart_pkg::MF_RX_DMA_READY: mf_pick = p.rx_rdy_n;
      default:                 mf_pick = 1'b1;
    endcase
  endfunction

  assign modem[0] = MODEM_IN_N_A;
  assign modem[1] = MODEM_IN_N_B;
  assign mf_sel   = dual_uart_pkg::mf_sel_e'(st_reg.alternate_function_select[`AFR_SEL_HI:`AFR_SEL_LO]);
  assign conc     = st_reg.alternate_function_select[`AFR_CONC];

  // Strobe decode on the synchronised copies; ctl is {cs_n, ior_n, iow_n}
  always_comb begin
    rd_active = !st_reg.s2_ctl[2] && !st_reg.s2_ctl[1];
    wr_end    = !st_reg.prev_ctl[2] && !st_reg.prev_ctl[0] && st_reg.s2_ctl[0];
    rd_end    = !st_reg.prev_ctl[2] && !st_reg.prev_ctl[1] && st_reg.s2_ctl[1];
    // The selected channel's latch bit decides the function register
    afr_hit   = is_afr(st_reg.s2_addr, dlab[st_reg.s2_chsel]);
    wr[0]     = wr_end && !afr_hit && (conc || !st_reg.s2_chsel); // RQ6
    wr[1]     = wr_end && !afr_hit && (conc || st_reg.s2_chsel); // RQ6
  end

  // The two channel register sets
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      uart_channel_regs u_regs (
        .clk        (CLK),
        .rst        (RESET),
        .wr_stb     (wr[ch]),
        .rd_done    (rd_end && !afr_hit && st_reg.s2_chsel == 1'(ch)),
        .addr       (st_reg.s2_addr),
        .wdata      (st_reg.s2_data),
        .rd_data    (rd_data[ch]),
        .dlab       (dlab[ch]),
        .modem_in_n (modem[ch]),
        .pins       (pins[ch])
      );
    end
  endgenerate

  // Next state: pin synchronisers, function register, read data, pins
  always_comb begin
    st_next          = st_reg;
    // Host pins are asynchronous: two flops before any use
    st_next.s1_ctl   = {CS_N, IOR_N, IOW_N};
    st_next.s2_ctl   = st_reg.s1_ctl;
    st_next.prev_ctl = st_reg.s2_ctl;
    st_next.s1_addr  = ADDR;
    st_next.s2_addr  = st_reg.s1_addr;
    st_next.s1_chsel = CHSEL;
    st_next.s2_chsel = st_reg.s1_chsel;
    st_next.s1_data  = DATA_IN;
    st_next.s2_data  = st_reg.s1_data;
    // Either channel's address reaches the single shared register
    if (wr_end && afr_hit) begin
      st_next.alternate_function_select = st_reg.s2_data & `AFR_USED_MASK; // RQ2 RQ3 RQ7
    end
    // Reads follow channel select only
    if (rd_active) begin
      if (afr_hit) begin
        st_next.dout = st_reg.alternate_function_select; // RQ2
      end else begin
        st_next.dout = rd_data[st_reg.s2_chsel]; // RQ8
      end
    end else begin
      st_next.dout = 8'h00;
    end
    st_next.oe_n  = !rd_active;
    st_next.pa    = pins[0];
    st_next.pb    = pins[1];
    st_next.mf[0] = mf_pick(mf_sel, pins[0]); // RQ4 RQ5
    st_next.mf[1] = mf_pick(mf_sel, pins[1]); // RQ4 RQ5
  end

  // State register; reset puts every pin in its documented idle level
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_reg          <= '0;
      st_reg.s1_ctl   <= `CTL_IDLE;
      st_reg.s2_ctl   <= `CTL_IDLE;
      st_reg.prev_ctl <= `CTL_IDLE;
      st_reg.alternate_function_select      <= `AFR_RST; // RQ10
      st_reg.oe_n     <= 1'b1;
      st_reg.pa       <= `PINS_RST; // RQ14
      st_reg.pb       <= `PINS_RST; // RQ14
      st_reg.mf       <= `MF_RST; // RQ14
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign DATA_OUT               = st_reg.dout;
  assign DATA_OE_N              = st_reg.oe_n;
  assign SERIAL_OUT_A           = st_reg.pa.serial_out;
  assign MULTI_FUNCTION_OUT_A   = st_reg.mf[0];
  assign SEND_REQUEST_OUT_A_N   = st_reg.pa.rts_n;
  assign TERMINAL_READY_OUT_A_N = st_reg.pa.dtr_n;
  assign IRQ_OUT_A              = st_reg.pa.irq;
  assign TX_DMA_READY_A         = st_reg.pa.tx_rdy;
  assign SERIAL_OUT_B           = st_reg.pb.serial_out;
  assign MULTI_FUNCTION_OUT_B   = st_reg.mf[1];
  assign SEND_REQUEST_OUT_B_N   = st_reg.pb.rts_n;
  assign TERMINAL_READY_OUT_B_N = st_reg.pb.dtr_n;
  assign IRQ_OUT_B              = st_reg.pb.irq;
  assign TX_DMA_READY_B         = st_reg.pb.tx_rdy;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  afr_write_a: assert property ( // RQ2
    wr_end && afr_hit |=> st_reg.alternate_function_select == ($past(st_reg.s2_data) & `AFR_USED_MASK))
    else $error("function register write lost");
  afr_unused_a: assert property ( // RQ3
    st_reg.alternate_function_select[7:3] == 5'h00)
    else $error("unused function bits not zero");
  mf_baud_a: assert property ( // RQ4
    mf_sel == dual_uart_pkg::MF_BAUD |=> MULTI_FUNCTION_OUT_A == $past(pins[0].baud_out))
    else $error("baud clock not on pin");
  mf_reserved_a: assert property ( // RQ5
    mf_sel == dual_uart_pkg::MF_RSVD |=> MULTI_FUNCTION_OUT_A && MULTI_FUNCTION_OUT_B)
    else $error("reserved code drives a source");
  conc_write_a: assert property ( // RQ6
    wr_end && !afr_hit && conc |-> wr == 2'h3)
    else $error("concurrent write missed a channel");
  single_write_a: assert property ( // RQ6
    wr_end && !afr_hit && !conc |-> wr[st_reg.s2_chsel] && !wr[!st_reg.s2_chsel])
    else $error("single write reached wrong channel");
  read_select_a: assert property ( // RQ8
    rd_active && !afr_hit && st_reg.s2_chsel |=> DATA_OUT == $past(rd_data[1]) && !DATA_OE_N)
    else $error("read ignored channel select");
  reset_pins_a: assert property ( // RQ14
    $fell(RESET) |-> SERIAL_OUT_A && SERIAL_OUT_B && SEND_REQUEST_OUT_A_N
      && SEND_REQUEST_OUT_B_N && TERMINAL_READY_OUT_A_N && TERMINAL_READY_OUT_B_N
      && MULTI_FUNCTION_OUT_A && MULTI_FUNCTION_OUT_B
      && !IRQ_OUT_A && !IRQ_OUT_B && !TX_DMA_READY_A && !TX_DMA_READY_B)
    else $error("pin not at reset level");

  conc_write_c: cover property (wr_end && !afr_hit && conc);
  afr_write_c: cover property (wr_end && afr_hit);
  baud_pin_c: cover property (mf_sel == dual_uart_pkg::MF_BAUD ##1 $rose(MULTI_FUNCTION_OUT_B));

endmodule // dual_uart_alt_function_reset

`default_nettype wire

// ---- dv/host_bus_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module host_bus_model (
  // Clock
  input  wire logic       clk,
  // Lines the host drives
  output logic            cs_n,
  output logic            ior_n,
  output logic            iow_n,
  output logic      [2:0] addr,
  output logic            chsel,
  output logic      [7:0] data,
  // Lines the device drives
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n
);
  // Idle bus from time zero
  initial begin
    cs_n  = 1'b1;
    ior_n = 1'b1;
    iow_n = 1'b1;
    addr  = 3'h0;
    chsel = 1'b0;
    data  = 8'h00;
  end

  // Release after hold; inverted leftovers catch a device that samples late
  task automatic release_bus();
    cs_n  = 1'b1;
    addr  = ~addr;
    chsel = ~chsel;
    data  = ~data;
    repeat (4) @(negedge clk);
  endtask

  // Write cycle: strobe low four cycles, qualifiers held four more
  task automatic write_reg(input logic ch, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    cs_n  = 1'b0;
    iow_n = 1'b0;
    addr  = a;
    chsel = ch;
    data  = d;
    repeat (4) @(negedge clk);
    iow_n = 1'b1;
    repeat (4) @(negedge clk);
    release_bus();
  endtask

  // Read cycle: data taken at a falling edge, where the registered outputs have settled
  task automatic read_reg(input logic ch, input logic [2:0] a,
                          output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    d  = 8'h00;
    @(negedge clk);
    cs_n  = 1'b0;
    ior_n = 1'b0;
    addr  = a;
    chsel = ch;
    for (n = 0; n < 10 && !ok; n++) begin
      @(negedge clk);
      if (data_oe_n === 1'b0) begin
        ok = 1'b1;
        d  = data_out;
      end
    end
    @(negedge clk);
    ior_n = 1'b1;
    for (n = 0; n < 10 && data_oe_n !== 1'b1; n++) @(negedge clk);
    release_bus();
  endtask
endmodule // host_bus_model

`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // Clock, reset and host bus
  logic                     clk;
  logic                     rst;
  logic                     cs_n;
  logic                     ior_n;
  logic                     iow_n;
  logic [2:0]               addr;
  logic                     chsel;
  logic [7:0]               wdata;
  logic [7:0]               rdata;
  logic                     oe_n;
  // Modem pins, held still so change bits stay clear
  dual_uart_pkg::modem_in_s mia;
  dual_uart_pkg::modem_in_s mib;
  // Pins: serial, multi-function, rts_n, dtr_n, irq, tx dma ready
  wire logic [5:0]          pa;
  wire logic [5:0]          pb;
  // Reference model and bookkeeping
  int                       scratch_byte [2];
  int                       line_control_reg [2];
  int                       modem_control_reg [2];
  int                       alternate_function_select;
  int                       fail_count = 0;
  int                       tests_run  = 0;
  int                       cycles     = 0;
  int                       n;
  int                       x;

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  dual_uart_alt_function_reset i_dut (
    .CLK(clk), .RESET(rst), .CS_N(cs_n), .IOR_N(ior_n), .IOW_N(iow_n),
    .ADDR(addr), .CHSEL(chsel), .DATA_IN(wdata), .DATA_OUT(rdata), .DATA_OE_N(oe_n),
    .MODEM_IN_N_A(mia), .MODEM_IN_N_B(mib),
    .SERIAL_OUT_A(pa[5]), .MULTI_FUNCTION_OUT_A(pa[4]), .SEND_REQUEST_OUT_A_N(pa[3]),
    .TERMINAL_READY_OUT_A_N(pa[2]), .IRQ_OUT_A(pa[1]), .TX_DMA_READY_A(pa[0]),
    .SERIAL_OUT_B(pb[5]), .MULTI_FUNCTION_OUT_B(pb[4]), .SEND_REQUEST_OUT_B_N(pb[3]),
    .TERMINAL_READY_OUT_B_N(pb[2]), .IRQ_OUT_B(pb[1]), .TX_DMA_READY_B(pb[0])
  );

  host_bus_model i_host (
    .clk(clk), .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n), .addr(addr),
    .chsel(chsel), .data(wdata), .data_out(rdata), .data_oe_n(oe_n)
  );

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard; the planned run needs about a tenth of this
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fail_count++;
      test_done();
    end
  end

  // Compare a register byte
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  // Compare a channel's pin levels
  task automatic check_pins(input logic [5:0] got, input logic [5:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: pins %b, expected %b", $time, got, exp);
    end
  endtask

  // Expected read; interrupt enable is never written, so it and the source stay idle
  function automatic logic [7:0] model_read(input int ch, input int a);
    case (a)
      2:       return line_control_reg[ch][7] ? 8'(alternate_function_select) : 8'h01;
      3:       return 8'(line_control_reg[ch]);
      4:       return 8'(modem_control_reg[ch]);
      5:       return 8'h60;
      6:       return {~(ch ? mib : mia), 4'h0};
      7:       return 8'(scratch_byte[ch]);
      default: return 8'h00;
    endcase
  endfunction

  // Expected pins; the baud source is judged separately by counting edges
  function automatic logic [5:0] exp_pins(input int ch);
    logic mf;
    mf = (((alternate_function_select >> 1) & 3) == 0) ? ~modem_control_reg[ch][3] : 1'b1;
    return {1'b1, mf, ~modem_control_reg[ch][1], ~modem_control_reg[ch][0], 2'b00};
  endfunction

  // Write through the host and mirror it; the concurrent bit is taken before the write
  task automatic wr(input int ch, input int a, input int d);
    int conc;
    conc = alternate_function_select & 1;
    i_host.write_reg(ch[0], a[2:0], d[7:0]);
    for (int c = 0; c < 2; c++) begin
      if (c == ch || conc == 1) begin
        case (a)
          2:       if (line_control_reg[c][7]) alternate_function_select = d & 7;
          3:       line_control_reg[c] = d;
          4:       modem_control_reg[c] = d;
          7:       scratch_byte[c] = d;
          default: ;
        endcase
      end
    end
  endtask

  // Read through the host and compare with the model
  task automatic rd(input int ch, input int a);
    logic [7:0] got;
    logic       ok;
    i_host.read_reg(ch[0], a[2:0], got, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: read never answered", $time);
    end
    check_byte(got, model_read(ch, a));
  endtask

  // Main sequence
  initial begin
    void'($urandom(38631));
    rst = 1'b1;
    mia = 4'($urandom);
    mib = 4'($urandom);
    scratch_byte = '{0, 0};
    line_control_reg = '{0, 0};
    modem_control_reg = '{0, 0};
    alternate_function_select = 0;
    repeat (10) @(negedge clk);
    check_pins(pa, 6'h3c);
    check_pins(pb, 6'h3c);
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check_pins(pa, 6'h3c);
    check_pins(pb, 6'h3c);
    // Reset contents of both register sets
    for (int c = 0; c < 2; c++) begin
      for (int a = 1; a < 7; a++) begin
        rd(c, a);
      end
      wr(c, 3, 8'h80);
      rd(c, 2);
      wr(c, 3, 8'h00);
    end
    // Scratch bytes stay apart per channel
    for (int i = 0; i < 4; i++) begin
      wr(0, 7, $urandom & 8'hff);
      wr(1, 7, (i == 0) ? 8'hff : $urandom & 8'hff);
      rd(0, 7);
      rd(1, 7);
    end
    // Unused bits drop, reserved code, then concurrent writes reach channel B
    wr(0, 3, 8'h80);
    wr(0, 2, 8'hff);
    rd(0, 2);
    check_pins(pa, exp_pins(0));
    wr(0, 7, $urandom & 8'hff);
    wr(0, 4, $urandom & 8'h0b);
    rd(1, 7);
    rd(1, 4);
    check_pins(pb, exp_pins(1));
    // Both latch bits set alike before the concurrent address-two write
    wr(1, 3, 8'h80);
    wr(1, 2, 8'h04);
    rd(0, 2);
    check_pins(pa, exp_pins(0));
    // Reads follow the select line with the concurrent bit set
    wr(0, 7, 8'h5a);
    wr(1, 7, 8'ha5);
    wr(1, 2, 8'h05);
    rd(0, 7);
    rd(1, 7);
    wr(0, 2, 8'h00);
    // Every source code on the multi-function pins
    wr(0, 4, 8'h09);
    wr(0, 0, 8'h02);
    for (int code = 0; code < 4; code++) begin
      wr(1, 2, code << 1);
      if (code == 1) begin
        n = 0;
        x = pa[4];
        repeat (40) begin
          @(negedge clk);
          if (pa[4] !== x[0]) n++;
          x = pa[4];
        end
        check_byte(8'(n), 8'd20);
      end else begin
        check_pins(pa, exp_pins(0));
        check_pins(pb, exp_pins(1));
      end
    end
    // Second reset in mid-run must undo written control and function values
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check_pins(pa, 6'h3c);
    rst = 1'b0;
    line_control_reg = '{0, 0};
    modem_control_reg = '{0, 0};
    alternate_function_select = 0;
    @(negedge clk);
    check_pins(pb, 6'h3c);
    rd(1, 4);
    wr(1, 3, 8'h80);
    rd(1, 2);
    test_done();
  end
endmodule // testbench

`default_nettype wire
